// ---- include/tsp_defines.svh ----
// Constants of the serial print controller: clock, rates, codes, map.
// What this block does
// - Seven data bits plus even parity bit.
// - Slowest rate frame is eleven units.
// - Faster rates frame is ten units.
// - Stop bits selectable one or two.
// - Rates 10, 15, 30, optional 120 cps.
// - Full duplex; optional half-duplex line control.
// - Transmitter sends all 128 seven-bit codes.
// - Uses TxD, RxD, RTS, CTS, DTR circuits.
// - Only the 94 graphic codes print.
// - Line length 75, 80 or 118.
// - Line feed one or two line steps.
// - Column counter drives next-column display.
// - Warning alarm eight positions before end.
// - Alarm after last position used.
// - Alarms only for locally generated characters.
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH
`define TSP_CLK_HZ      10000000
`define TSP_CPS_10      10
`define TSP_CPS_15      15
`define TSP_CPS_30      30
`define TSP_CPS_120     120
`define TSP_FRM_2STOP   4'hB
`define TSP_FRM_1STOP   4'hA
`define TSP_CYC_W       17
`define TSP_RX_STOP_IDX 4'h9
`define TSP_AW          8
`define TSP_A_CTRL      8'h00
`define TSP_A_TXDATA    8'h04
`define TSP_A_STATUS    8'h08
`define TSP_A_RXDATA    8'h0C
`define TSP_A_COLUMN    8'h10
`define TSP_A_ISTAT     8'h14
`define TSP_A_IMASK     8'h18
`define TSP_CTRL_W      9
`define TSP_CTRL_RST    9'h100
`define TSP_IRQ_W       5
`define TSP_I_TXDONE    0
`define TSP_I_RXDONE    1
`define TSP_I_RXERR     2
`define TSP_I_WARN      3
`define TSP_I_EOL       4
`define TSP_RESP_OKAY   2'h0
`define TSP_RESP_SLVERR 2'h2
`define TSP_LEN_75      7'h4B
`define TSP_LEN_80      7'h50
`define TSP_LEN_118     7'h76
`define TSP_WARN_GAP    7'h08
`define TSP_COL_FIRST   7'h01
`define TSP_CH_BS       7'h08
`define TSP_CH_LF       7'h0A
`define TSP_CH_CR       7'h0D
`define TSP_CH_SP       7'h20
`define TSP_CH_TILDE    7'h7E
`define TSP_LF_SINGLE   2'h1
`define TSP_LF_DOUBLE   2'h2
`endif

// ---- include/tsp_pkg.sv ----
// Types shared by the serial print controller modules.
package tsp_pkg;
	typedef enum logic [1:0] {
		TSP_RATE_10  = 2'h0,
		TSP_RATE_15  = 2'h1,
		TSP_RATE_30  = 2'h2,
		TSP_RATE_120 = 2'h3
	} tsp_rate_t;
	typedef enum logic [1:0] {
		TSP_BUS_IDLE = 2'h1,
		TSP_BUS_RESP = 2'h2
	} tsp_bus_st_t;
	typedef struct packed {
		logic       dtr_en;
		logic       half_dup;
		logic [1:0] len_sel;
		logic       dbl_space;
		logic       two_stop;
		logic       stop_ovr;
		tsp_rate_t  rate;
	} tsp_ctrl_t;
	typedef struct packed {
		logic       perr;
		logic       ferr;
		logic [6:0] code;
	} tsp_rxchar_t;
endpackage : tsp_pkg

// ---- rtl/tsp_tx.sv ----
// Asynchronous character transmitter.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tsp_tx
	import tsp_pkg::*;
#(
	parameter int CW = `TSP_CYC_W
)
(
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic          start_in,
	input  wire logic [6:0]    code_in,
	input  wire logic [CW-1:0] bit_cyc_in,
	input  wire logic          two_stop_in,
	output logic               txd_out,
	output logic               busy_out,
	output logic               done_out
);
	logic [9:0]    sh_q;
	logic [3:0]    left_q;
	logic [CW-1:0] cnt_q;
	// Frame shifter: start bit, data LSB first, parity, stop bits
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sh_q     <= 10'h3FF;
			left_q   <= 4'h0;
			cnt_q    <= '0;
			txd_out  <= 1'b1;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (!busy_out && start_in)
			begin
				txd_out  <= 1'b0;
				sh_q     <= {2'h3, ^code_in, code_in};
				left_q   <= (two_stop_in ? `TSP_FRM_2STOP : `TSP_FRM_1STOP) - 4'h1;
				cnt_q    <= bit_cyc_in - 1'b1;
				busy_out <= 1'b1;
			end
			else if (busy_out && cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
			else if (busy_out && left_q == 4'h0)
			begin
				busy_out <= 1'b0;
				done_out <= 1'b1;
				txd_out  <= 1'b1;
			end
			else if (busy_out)
			begin
				txd_out <= sh_q[0];
				sh_q    <= {1'b1, sh_q[9:1]};
				left_q  <= left_q - 4'h1;
				cnt_q   <= bit_cyc_in - 1'b1;
			end
		end
	end
endmodule : tsp_tx

// ---- rtl/tsp_rx.sv ----
// Asynchronous character receiver, mid-bit sampling.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tsp_rx
	import tsp_pkg::*;
#(
	parameter int CW = `TSP_CYC_W
)
(
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic          rxd_in,
	input  wire logic [CW-1:0] bit_cyc_in,
	output tsp_rxchar_t        char_out,
	output logic               done_out
);
	logic          act_q;
	logic          prev_q;
	logic [3:0]    idx_q;
	logic [7:0]    sh_q;
	logic [CW-1:0] cnt_q;
	// Start edge search, then one sample per bit
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			act_q    <= 1'b0;
			prev_q   <= 1'b1;
			idx_q    <= 4'h0;
			sh_q     <= 8'h00;
			cnt_q    <= '0;
			char_out <= '0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			prev_q   <= rxd_in;
			if (!act_q)
			begin
				if (prev_q && !rxd_in)
				begin
					act_q <= 1'b1;
					idx_q <= 4'h0;
					cnt_q <= bit_cyc_in >> 1;
				end
			end
			else if (cnt_q != '0)
				cnt_q <= cnt_q - 1'b1;
			else
			begin
				cnt_q <= bit_cyc_in - 1'b1;
				idx_q <= idx_q + 4'h1;
				if (idx_q == 4'h0 && rxd_in)
					act_q <= 1'b0; // Glitch, not a start bit
				else if (idx_q == `TSP_RX_STOP_IDX)
				begin
					act_q         <= 1'b0;
					done_out      <= 1'b1;
					char_out.code <= sh_q[6:0];
					char_out.perr <= ^sh_q;
					char_out.ferr <= !rxd_in;
				end
				else if (idx_q != 4'h0)
					sh_q <= {rxd_in, sh_q[7:1]};
			end
		end
	end
endmodule : tsp_rx

// ---- rtl/tsp_top.sv ----
// Serial print controller top: AXI4-Lite registers, modem pins, column logic.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tsp_top
	import tsp_pkg::*;
#(
	parameter logic [`TSP_CYC_W-1:0] BIT_CYC_10  =
		`TSP_CYC_W'(`TSP_CLK_HZ / (`TSP_CPS_10 * 11)),
	parameter logic [`TSP_CYC_W-1:0] BIT_CYC_15  =
		`TSP_CYC_W'(`TSP_CLK_HZ / (`TSP_CPS_15 * 10)),
	parameter logic [`TSP_CYC_W-1:0] BIT_CYC_30  =
		`TSP_CYC_W'(`TSP_CLK_HZ / (`TSP_CPS_30 * 10)),
	parameter logic [`TSP_CYC_W-1:0] BIT_CYC_120 =
		`TSP_CYC_W'(`TSP_CLK_HZ / (`TSP_CPS_120 * 10)),
	parameter bit                    RATE_120_EN = 1'b1
)
(
	input  wire logic              CORE_CLK_IN,
	input  wire logic              RST_IN,
	input  wire logic [`TSP_AW-1:0] AXI_AWADDR_IN,
	input  wire logic              AXI_AWVALID_IN,
	output logic                   AXI_AWREADY_OUT,
	input  wire logic [31:0]       AXI_WDATA_IN,
	input  wire logic [3:0]        AXI_WSTRB_IN,
	input  wire logic              AXI_WVALID_IN,
	output logic                   AXI_WREADY_OUT,
	output logic [1:0]             AXI_BRESP_OUT,
	output logic                   AXI_BVALID_OUT,
	input  wire logic              AXI_BREADY_IN,
	input  wire logic [`TSP_AW-1:0] AXI_ARADDR_IN,
	input  wire logic              AXI_ARVALID_IN,
	output logic                   AXI_ARREADY_OUT,
	output logic [31:0]            AXI_RDATA_OUT,
	output logic [1:0]             AXI_RRESP_OUT,
	output logic                   AXI_RVALID_OUT,
	input  wire logic              AXI_RREADY_IN,
	output logic                   TXD_OUT,
	input  wire logic              RXD_IN,
	output logic                   RTS_OUT,
	input  wire logic              CTS_IN,
	output logic                   DTR_OUT,
	output logic [6:0]             COL_DISP_OUT,
	output logic                   PRINT_STB_OUT,
	output logic [6:0]             PRINT_CODE_OUT,
	output logic                   PRINT_GLYPH_OUT,
	output logic                   LF_STB_OUT,
	output logic [1:0]             LF_STEPS_OUT,
	output logic                   WARN_ALARM_OUT,
	output logic                   EOL_ALARM_OUT,
	output logic                   IRQ_OUT
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0]              sync1_q;
	logic [1:0]              sync2_q;
	logic                    rxd_s;
	logic                    cts_s;
	tsp_bus_st_t             wst_q;
	tsp_bus_st_t             rst_q;
	logic                    got_aw_q;
	logic                    got_w_q;
	logic [`TSP_AW-1:0]      awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic [31:0]             wbe;
	logic [31:0]             wv;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    wr_hit;
	logic                    rd_hit;
	logic [31:0]             rd_val;
	tsp_ctrl_t               ctrl_q;
	logic [`TSP_IRQ_W-1:0]   istat_q;
	logic [`TSP_IRQ_W-1:0]   imask_q;
	logic [`TSP_IRQ_W-1:0]   iset;
	logic [`TSP_IRQ_W-1:0]   iclr;
	logic                    tx_pend_q;
	logic [6:0]              tx_code_q;
	logic                    tx_start;
	logic                    tx_busy;
	logic                    tx_done;
	logic                    tx_line;
	logic                    loc_pend_q;
	logic [6:0]              loc_code_q;
	tsp_rxchar_t             rx_char;
	tsp_rxchar_t             rx_hold_q;
	logic                    rx_done;
	logic                    rx_valid_q;
	logic [`TSP_CYC_W-1:0]   bit_cyc;
	logic                    two_stop;
	logic [6:0]              line_len;
	logic [6:0]              col_q;
	logic                    prt_ev;
	logic                    prt_loc;
	logic [6:0]              prt_code;
	logic                    prt_graphic;
	logic                    warn_ev;
	logic                    eol_ev;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for received data and clear to send
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			sync1_q <= 2'h3;
			sync2_q <= 2'h3;
		end
		else
		begin
			sync1_q <= {CTS_IN, RXD_IN};
			sync2_q <= sync1_q;
		end
	end
	assign rxd_s = sync2_q[0];
	assign cts_s = sync2_q[1];

	////////////////////////////////////////////////////////////////////////
	// Character rate and stop bit selection
	always_comb
	begin
		case (ctrl_q.rate)
			TSP_RATE_10:  bit_cyc = BIT_CYC_10;
			TSP_RATE_15:  bit_cyc = BIT_CYC_15;
			TSP_RATE_30:  bit_cyc = BIT_CYC_30;
			TSP_RATE_120: bit_cyc = RATE_120_EN ? BIT_CYC_120 : BIT_CYC_30;
			default:      bit_cyc = BIT_CYC_10;
		endcase
	end
	// Default two stops only at slowest rate; override picks either
	assign two_stop = ctrl_q.stop_ovr ? ctrl_q.two_stop :
		(ctrl_q.rate == TSP_RATE_10);

	// Configured print line length
	always_comb
	begin
		case (ctrl_q.len_sel)
			2'h1:    line_len = `TSP_LEN_80;
			2'h2:    line_len = `TSP_LEN_118;
			default: line_len = `TSP_LEN_75;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data taken in either order
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_be
			assign wbe[8*gi +: 8] = {8{wstrb_q[gi]}};
		end
	endgenerate
	assign wv      = wdata_q & wbe;
	assign wr_fire = (wst_q == TSP_BUS_IDLE) && got_aw_q && got_w_q;
	assign wr_hit  = (awaddr_q == `TSP_A_CTRL) || (awaddr_q == `TSP_A_TXDATA) ||
		(awaddr_q == `TSP_A_ISTAT) || (awaddr_q == `TSP_A_IMASK);

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			wst_q           <= TSP_BUS_IDLE;
			got_aw_q        <= 1'b0;
			got_w_q         <= 1'b0;
			awaddr_q        <= '0;
			wdata_q         <= 32'h0000_0000;
			wstrb_q         <= 4'h0;
			AXI_AWREADY_OUT <= 1'b1;
			AXI_WREADY_OUT  <= 1'b1;
			AXI_BVALID_OUT  <= 1'b0;
			AXI_BRESP_OUT   <= `TSP_RESP_OKAY;
		end
		else
		begin
			if (AXI_AWVALID_IN && AXI_AWREADY_OUT)
			begin
				got_aw_q        <= 1'b1;
				awaddr_q        <= AXI_AWADDR_IN;
				AXI_AWREADY_OUT <= 1'b0;
			end
			if (AXI_WVALID_IN && AXI_WREADY_OUT)
			begin
				got_w_q        <= 1'b1;
				wdata_q        <= AXI_WDATA_IN;
				wstrb_q        <= AXI_WSTRB_IN;
				AXI_WREADY_OUT <= 1'b0;
			end
			case (wst_q)
				TSP_BUS_IDLE:
					if (wr_fire)
					begin
						wst_q          <= TSP_BUS_RESP;
						AXI_BVALID_OUT <= 1'b1;
						AXI_BRESP_OUT  <= wr_hit ? `TSP_RESP_OKAY : `TSP_RESP_SLVERR;
					end
				TSP_BUS_RESP:
					if (AXI_BREADY_IN)
					begin
						wst_q           <= TSP_BUS_IDLE;
						AXI_BVALID_OUT  <= 1'b0;
						got_aw_q        <= 1'b0;
						got_w_q         <= 1'b0;
						AXI_AWREADY_OUT <= 1'b1;
						AXI_WREADY_OUT  <= 1'b1;
					end
				default: wst_q <= TSP_BUS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel with data mux
	assign rd_fire = AXI_ARVALID_IN && AXI_ARREADY_OUT;
	always_comb
	begin
		rd_hit = 1'b1;
		case (AXI_ARADDR_IN)
			`TSP_A_CTRL:   rd_val = {23'h0, ctrl_q};
			`TSP_A_TXDATA: rd_val = {25'h0, tx_code_q};
			`TSP_A_STATUS: rd_val = {26'h0, rx_hold_q.ferr, rx_hold_q.perr,
				rx_valid_q, cts_s, tx_pend_q, tx_busy};
			`TSP_A_RXDATA: rd_val = {23'h0, rx_valid_q, 1'b0, rx_hold_q.code};
			`TSP_A_COLUMN: rd_val = {25'h0, col_q};
			`TSP_A_ISTAT:  rd_val = {27'h0, istat_q};
			`TSP_A_IMASK:  rd_val = {27'h0, imask_q};
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			rst_q           <= TSP_BUS_IDLE;
			AXI_ARREADY_OUT <= 1'b1;
			AXI_RVALID_OUT  <= 1'b0;
			AXI_RDATA_OUT   <= 32'h0000_0000;
			AXI_RRESP_OUT   <= `TSP_RESP_OKAY;
		end
		else
		begin
			case (rst_q)
				TSP_BUS_IDLE:
					if (rd_fire)
					begin
						rst_q           <= TSP_BUS_RESP;
						AXI_ARREADY_OUT <= 1'b0;
						AXI_RVALID_OUT  <= 1'b1;
						AXI_RDATA_OUT   <= rd_val;
						AXI_RRESP_OUT   <= rd_hit ? `TSP_RESP_OKAY : `TSP_RESP_SLVERR;
					end
				TSP_BUS_RESP:
					if (AXI_RREADY_IN)
					begin
						rst_q           <= TSP_BUS_IDLE;
						AXI_ARREADY_OUT <= 1'b1;
						AXI_RVALID_OUT  <= 1'b0;
					end
				default: rst_q <= TSP_BUS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, mask and interrupt status registers
	assign iclr = (wr_fire && awaddr_q == `TSP_A_ISTAT) ? wv[`TSP_IRQ_W-1:0] : '0;
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			ctrl_q  <= `TSP_CTRL_RST;
			imask_q <= '0;
			istat_q <= '0;
			IRQ_OUT <= 1'b0;
		end
		else
		begin
			if (wr_fire && awaddr_q == `TSP_A_CTRL)
				ctrl_q <= (ctrl_q & ~wbe[`TSP_CTRL_W-1:0]) | wv[`TSP_CTRL_W-1:0];
			if (wr_fire && awaddr_q == `TSP_A_IMASK)
				imask_q <= (imask_q & ~wbe[`TSP_IRQ_W-1:0]) | wv[`TSP_IRQ_W-1:0];
			istat_q <= (istat_q & ~iclr) | iset; // Set wins over clear
			IRQ_OUT <= |(((istat_q & ~iclr) | iset) & imask_q);
		end
	end
	assign iset[`TSP_I_TXDONE] = tx_done;
	assign iset[`TSP_I_RXDONE] = rx_done;
	assign iset[`TSP_I_RXERR]  = rx_done && (rx_char.perr || rx_char.ferr);
	assign iset[`TSP_I_WARN]   = warn_ev;
	assign iset[`TSP_I_EOL]    = eol_ev;

	////////////////////////////////////////////////////////////////////////
	// Transmit request: held until idle and, in half duplex, clear to send
	assign tx_start = tx_pend_q && !tx_busy && (!ctrl_q.half_dup || cts_s);
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			tx_pend_q  <= 1'b0;
			tx_code_q  <= 7'h00;
			loc_pend_q <= 1'b0;
			loc_code_q <= 7'h00;
			RTS_OUT    <= 1'b0;
			DTR_OUT    <= 1'b0;
		end
		else
		begin
			if (wr_fire && awaddr_q == `TSP_A_TXDATA && wstrb_q[0] && !tx_pend_q)
			begin
				tx_pend_q  <= 1'b1;
				tx_code_q  <= wv[6:0];
				loc_pend_q <= 1'b1;
				loc_code_q <= wv[6:0];
			end
			else
			begin
				if (tx_start)
					tx_pend_q <= 1'b0;
				if (loc_pend_q && !rx_done)
					loc_pend_q <= 1'b0;
			end
			// Full duplex drives RTS from dtr_en; half duplex raises it per character
			RTS_OUT <= ctrl_q.half_dup ? (tx_pend_q || tx_busy) : ctrl_q.dtr_en;
			DTR_OUT <= ctrl_q.dtr_en;
		end
	end

	tsp_tx #(
		.CW          (`TSP_CYC_W)
	) u_tx (
		.clk_in      (CORE_CLK_IN),
		.rst_in      (RST_IN),
		.start_in    (tx_start),
		.code_in     (tx_code_q),
		.bit_cyc_in  (bit_cyc),
		.two_stop_in (two_stop),
		.txd_out     (tx_line),
		.busy_out    (tx_busy),
		.done_out    (tx_done)
	);
	assign TXD_OUT = tx_line;

	tsp_rx #(
		.CW         (`TSP_CYC_W)
	) u_rx (
		.clk_in     (CORE_CLK_IN),
		.rst_in     (RST_IN),
		.rxd_in     (rxd_s),
		.bit_cyc_in (bit_cyc),
		.char_out   (rx_char),
		.done_out   (rx_done)
	);

	// Received character holding register, emptied by reading it
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			rx_hold_q  <= '0;
			rx_valid_q <= 1'b0;
		end
		else if (rx_done)
		begin
			rx_hold_q  <= rx_char;
			rx_valid_q <= 1'b1;
		end
		else if (rd_fire && AXI_ARADDR_IN == `TSP_A_RXDATA)
			rx_valid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Print event: received character first, local one the next free cycle
	assign prt_ev      = rx_done || loc_pend_q;
	assign prt_loc     = !rx_done;
	assign prt_code    = rx_done ? rx_char.code : loc_code_q;
	assign prt_graphic = (prt_code > `TSP_CH_SP) && (prt_code <= `TSP_CH_TILDE);
	assign warn_ev     = prt_ev && prt_loc && (prt_code >= `TSP_CH_SP) &&
		(prt_code <= `TSP_CH_TILDE) && (col_q + 7'h01 == line_len - `TSP_WARN_GAP);
	assign eol_ev      = prt_ev && prt_loc && (prt_code >= `TSP_CH_SP) &&
		(prt_code <= `TSP_CH_TILDE) && (col_q == line_len);

	// Column counter, printer strobes and alarms
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			col_q           <= `TSP_COL_FIRST;
			COL_DISP_OUT    <= `TSP_COL_FIRST;
			PRINT_STB_OUT   <= 1'b0;
			PRINT_CODE_OUT  <= 7'h00;
			PRINT_GLYPH_OUT <= 1'b0;
			LF_STB_OUT      <= 1'b0;
			LF_STEPS_OUT    <= `TSP_LF_SINGLE;
			WARN_ALARM_OUT  <= 1'b0;
			EOL_ALARM_OUT   <= 1'b0;
		end
		else
		begin
			PRINT_STB_OUT  <= prt_ev;
			PRINT_CODE_OUT <= prt_ev ? prt_code : PRINT_CODE_OUT;
			// No glyph past the last position or for control codes
			PRINT_GLYPH_OUT <= prt_ev && prt_graphic && (col_q <= line_len);
			LF_STB_OUT      <= prt_ev && (prt_code == `TSP_CH_LF);
			LF_STEPS_OUT    <= ctrl_q.dbl_space ? `TSP_LF_DOUBLE : `TSP_LF_SINGLE;
			WARN_ALARM_OUT  <= warn_ev;
			EOL_ALARM_OUT   <= eol_ev;
			COL_DISP_OUT    <= col_q;
			if (prt_ev)
			begin
				if (prt_code == `TSP_CH_CR)
					col_q <= `TSP_COL_FIRST;
				else if (prt_code == `TSP_CH_BS && col_q > `TSP_COL_FIRST)
					col_q <= col_q - 7'h01;
				else if (prt_code >= `TSP_CH_SP && prt_code <= `TSP_CH_TILDE &&
					col_q <= line_len)
					col_q <= col_q + 7'h01;
			end
		end
	end
endmodule : tsp_top

// ---- sim/tsp_assertions.sv ----
// Concurrent port checks of the serial print controller.
`timescale 1ns/100ps
module tsp_assertions
(
	input wire logic       CORE_CLK_IN,
	input wire logic       RST_IN,
	input wire logic       AXI_AWVALID_IN,
	input wire logic       AXI_AWREADY_OUT,
	input wire logic       AXI_WVALID_IN,
	input wire logic       AXI_WREADY_OUT,
	input wire logic       AXI_BVALID_OUT,
	input wire logic       TXD_OUT,
	input wire logic [6:0] COL_DISP_OUT,
	input wire logic       PRINT_STB_OUT,
	input wire logic [6:0] PRINT_CODE_OUT,
	input wire logic       PRINT_GLYPH_OUT,
	input wire logic       LF_STB_OUT,
	input wire logic [1:0] LF_STEPS_OUT,
	input wire logic       WARN_ALARM_OUT,
	input wire logic       EOL_ALARM_OUT
);
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	////////////////////////////////////////////////////////////
	// Steps: both write items taken; a spacing bit held low
	sequence s_wr_take;
		AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
	endsequence
	sequence s_space_bit;
		!TXD_OUT [*8];
	endsequence
	property p_wr_resp; s_wr_take |=> ##1 AXI_BVALID_OUT; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_mark_reset; $fell(RST_IN) |-> TXD_OUT; endproperty
	a_mark_reset: assert property (p_mark_reset) else $error("line not marking");
	property p_start_hold; $fell(TXD_OUT) |-> s_space_bit; endproperty
	a_start_hold: assert property (p_start_hold) else $error("short bit");
	property p_glyph;
		PRINT_GLYPH_OUT |-> PRINT_STB_OUT && PRINT_CODE_OUT inside {[7'h21:7'h7E]};
	endproperty
	a_glyph: assert property (p_glyph) else $error("glyph for odd code");
	property p_lf_steps; LF_STB_OUT |-> LF_STEPS_OUT inside {2'h1, 2'h2}; endproperty
	a_lf_steps: assert property (p_lf_steps) else $error("bad feed steps");
	property p_col_range; COL_DISP_OUT inside {[7'h01:7'h77]}; endproperty
	a_col_range: assert property (p_col_range) else $error("column out of range");
	property p_cr_home;
		PRINT_STB_OUT && PRINT_CODE_OUT == 7'h0D |-> ##[0:3] COL_DISP_OUT == 7'h01;
	endproperty
	a_cr_home: assert property (p_cr_home) else $error("return missed");
	property p_warn_col;
		WARN_ALARM_OUT |-> ##[0:3] COL_DISP_OUT inside {7'h43, 7'h48, 7'h6E};
	endproperty
	a_warn_col: assert property (p_warn_col) else $error("warning misplaced");
	property p_eol_col;
		EOL_ALARM_OUT |-> ##[0:3] COL_DISP_OUT inside {7'h4C, 7'h51, 7'h77};
	endproperty
	a_eol_col: assert property (p_eol_col) else $error("line end misplaced");
endmodule : tsp_assertions
bind tsp_top tsp_assertions u_chk (.*);

// ---- sim/tsp_line_model.sv ----
// Line-side partner: sends frames on received data, decodes transmitted data.
`timescale 1ns/100ps
module tsp_line_model
#(
	parameter int BC = 16
)
(
	input  wire logic clk_in,
	input  wire logic txd_in,
	output logic      rxd_out,
	output logic      cts_out
);
	int         cyc_q;
	int         start_q;
	int         gap;
	int         got;
	logic [8:0] bits;
	logic [6:0] code;
	logic       par_ok;
	////////////////////////////////////////////////////////////
	// Idle line marks, modem always clear to send
	initial
	begin
		rxd_out = 1'h1;
		cts_out = 1'h1;
	end
	// Cycle count for start-to-start spacing
	always @(posedge clk_in) cyc_q <= cyc_q + 1;
	// Frame decoder, sampling mid-bit from the start edge
	always
	begin
		@(negedge txd_in);
		gap = cyc_q - start_q;
		start_q = cyc_q;
		repeat (BC / 2) @(posedge clk_in);
		for (int i = 0; i < 9; i++)
		begin
			repeat (BC) @(posedge clk_in);
			bits[i] = txd_in;
		end
		code = bits[6:0];
		par_ok = ~^bits[7:0];
		got++;
	end
	// One frame with two stops, parity optionally spoilt
	task automatic send(input logic [6:0] c, input logic bad);
		logic [10:0] f;
		f = {2'h3, ^c ^ bad, c, 1'h0};
		for (int i = 0; i < 11; i++)
		begin
			rxd_out <= f[i];
			repeat (BC) @(posedge clk_in);
		end
	endtask : send
endmodule : tsp_line_model

// ---- sim/tb_top.sv ----
// Self-checking bench of the serial print controller.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tb_top;
	localparam int BC  = 16;
	localparam int LIM = 90000;
	logic             clk, rst, awv, wv, bre, arv, rre;
	logic [7:0]       awa, ara;
	logic [31:0]      wd, rdat;
	logic [1:0]       resp, steps;
	wire logic        awr, wrd, bv, arr, rv, txd, rxd, cts, rts, dtr, stb, gl, lfs, wa, ea, irq;
	wire logic [1:0]  br, rr, lst;
	wire logic [31:0] rd;
	wire logic [6:0]  col, pc;
	int               err_total, n_tests, cyc, n_warn, n_eol, n_gl;
	tsp_top #(.BIT_CYC_10(17'(BC)), .BIT_CYC_15(17'(BC)), .BIT_CYC_30(17'(BC)),
		.BIT_CYC_120(17'(BC)), .RATE_120_EN(1'h1)) uut (
		.CORE_CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv),
		.AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wv),
		.AXI_WREADY_OUT(wrd), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bre),
		.AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rd),
		.AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre), .TXD_OUT(txd),
		.RXD_IN(rxd), .RTS_OUT(rts), .CTS_IN(cts), .DTR_OUT(dtr), .COL_DISP_OUT(col),
		.PRINT_STB_OUT(stb), .PRINT_CODE_OUT(pc), .PRINT_GLYPH_OUT(gl), .LF_STB_OUT(lfs),
		.LF_STEPS_OUT(lst), .WARN_ALARM_OUT(wa), .EOL_ALARM_OUT(ea), .IRQ_OUT(irq));
	tsp_line_model #(.BC(BC)) lm (.clk_in(clk), .txd_in(txd), .rxd_out(rxd), .cts_out(cts));
	////////////////////////////////////////////////////////////
	// Clock of 100 ns
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// Event counters and the run ceiling
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		n_warn <= n_warn + wa;
		n_eol <= n_eol + ea;
		n_gl <= n_gl + gl;
		if (lfs) steps <= lst;
		if (cyc == LIM)
		begin
			err_total++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		bit ta, tw;
		@(posedge clk);
		awa <= a;
		wd <= d;
		{awv, wv, bre} <= 3'h7;
		ta = 1'h0;
		tw = 1'h0;
		while (!(ta && tw))
		begin
			@(posedge clk);
			ta = ta || awr;
			tw = tw || wrd;
			awv <= !ta;
			wv <= !tw;
		end
		while (!bv) @(posedge clk);
		resp = br;
		bre <= 1'h0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		{arv, rre} <= 2'h3;
		do @(posedge clk); while (!arr);
		arv <= 1'h0;
		while (!rv) @(posedge clk);
		rdat = rd;
		resp = rr;
		rre <= 1'h0;
	endtask : bus_rd
	// Local character once the transmit slot is free
	task automatic put(input logic [6:0] c);
		do bus_rd(`TSP_A_STATUS); while (rdat[1]);
		bus_wr(`TSP_A_TXDATA, {25'h0, c});
		repeat (3) @(posedge clk);
	endtask : put
	task automatic put_n(input int n, input logic [6:0] c);
		for (int i = 0; i < n; i++) put(c);
	endtask : put_n
	task automatic wait_got(input int n);
		while (lm.got < n) @(posedge clk);
	endtask : wait_got
	////////////////////////////////////////////////////////////
	task automatic t_reset;
		bus_rd(`TSP_A_CTRL);
		chk(rdat, {23'h0, `TSP_CTRL_RST});
		bus_rd(`TSP_A_COLUMN);
		chk(rdat, 32'h1);
		bus_rd(8'h1C);
		chk({resp, rdat}, {`TSP_RESP_SLVERR, 32'h0});
		bus_wr(8'h1C, 32'h0);
		chk(resp, `TSP_RESP_SLVERR);
		chk({dtr, rts, txd}, 3'h7);
		$display("done: reset");
	endtask : t_reset
	task automatic t_frames;
		logic [8:0] cfg [6] = '{9'h100, 9'h101, 9'h102, 9'h103, 9'h10E, 9'h104};
		int         un [6] = '{11, 10, 10, 10, 11, 10};
		int         g;
		int         g0;
		g0 = n_gl;
		for (int i = 0; i < 6; i++)
		begin
			g = lm.got;
			bus_wr(`TSP_A_CTRL, {23'h0, cfg[i]});
			put(7'h00);
			put(7'h7F);
			wait_got(g + 2);
			chk(lm.gap / BC, un[i]);
			chk({lm.par_ok, lm.code}, 8'hFF);
		end
		chk(n_gl, g0);
		$display("done: frames");
	endtask : t_frames
	task automatic t_rx;
		int g;
		bus_wr(`TSP_A_CTRL, 32'h100);
		bus_wr(`TSP_A_IMASK, 32'h2);
		bus_wr(`TSP_A_ISTAT, 32'h1F);
		g = lm.got;
		fork
			put(`TSP_CH_CR);
			lm.send(7'h42, 1'h0);
		join
		wait_got(g + 1);
		bus_rd(`TSP_A_RXDATA);
		chk(rdat, 32'h142);
		chk({irq, lm.code}, {1'h1, `TSP_CH_CR});
		bus_wr(`TSP_A_ISTAT, 32'h2);
		repeat (2) @(posedge clk);
		chk(irq, 1'h0);
		bus_wr(`TSP_A_IMASK, 32'h0);
		lm.send(7'h43, 1'h1);
		repeat (2) @(posedge clk);
		bus_rd(`TSP_A_STATUS);
		chk({irq, rdat[4]}, 2'h1);
		bus_wr(`TSP_A_CTRL, 32'h180);
		put(7'h41);
		chk(rts, 1'h1);
		repeat (12 * BC) @(posedge clk);
		chk(rts, 1'h0);
		$display("done: duplex and interrupt");
	endtask : t_rx
	task automatic t_lf;
		bus_wr(`TSP_A_CTRL, 32'h100);
		put(`TSP_CH_LF);
		chk(steps, `TSP_LF_SINGLE);
		bus_wr(`TSP_A_CTRL, 32'h110);
		put(`TSP_CH_LF);
		chk(steps, `TSP_LF_DOUBLE);
		$display("done: line feed");
	endtask : t_lf
	task automatic t_col;
		int w0;
		int e0;
		int g0;
		bus_wr(`TSP_A_CTRL, 32'h100);
		put(`TSP_CH_CR);
		put_n(64, 7'h41);
		w0 = n_warn;
		e0 = n_eol;
		for (int i = 0; i < 3; i++) lm.send(7'h42, 1'h0);
		chk({n_warn, col}, {w0, 7'h44});
		put_n(7, 7'h41);
		chk(n_eol, e0);
		put(7'h41);
		chk({n_eol, col}, {e0 + 1, 7'h4C});
		g0 = n_gl;
		put(7'h41);
		chk(n_gl, g0);
		put(`TSP_CH_BS);
		chk(col, 7'h4B);
		put(`TSP_CH_CR);
		put_n(66, 7'h41);
		chk({n_warn, col}, {w0 + 1, 7'h43});
		bus_wr(`TSP_A_CTRL, 32'h120);
		put_n(4, 7'h41);
		chk(n_warn, w0 + 1);
		put(7'h41);
		chk(n_warn, w0 + 2);
		bus_wr(`TSP_A_CTRL, 32'h140);
		put_n(38, 7'h41);
		chk(n_warn, w0 + 3);
		$display("done: column");
	endtask : t_col
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// Reset for five cycles, then the scenarios
	initial
	begin
		rst = 1'h1;
		{awv, wv, bre, arv, rre} = 5'h00;
		{awa, ara} = 16'h0000;
		wd = 32'h0;
		steps = 2'h0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_frames();
		t_rx();
		t_lf();
		t_col();
		stop_test();
	end
endmodule : tb_top
